// ===== rtl/pmx_defs.svh
// Behaviour
// - Freeze-present flag reads one
// - State from enable, freeze, overflow flags
// - Disabled monitors' flags still count
// - State change takes effect next cycle
// - Even flag ignored when odd chains
// - Unignored even overflow carries then waits
// - Cycle counter may count during wait
// - Cycle flag ignored if counting in wait
// - Debug policy: always, never, or controlled
// - Halt-debug-present flag reads one
// - Cycle counter counts unhalted own cycles
// - Cycle-counter-present flag reads one
// - Cycle counter aliases event counter 31
// - Optional divide-by-64 prescaler, flag one
// - Second state counts only if disable set
// - Without extension counter 31 is ordinary
// - Group-count field nonzero with groups
// - Per-group maximum by groups and width
// - Group m starts at m times maximum
// - Odd counter counts even overflow carry
// - Carry lands with the even update
`ifndef PMX_DEFS_SVH
`define PMX_DEFS_SVH
// ==========================================================
// Register byte offsets
`define PMX_OFF_CNT0 12'h000
`define PMX_OFF_CCNT 12'h07c
`define PMX_OFF_TYPE0 12'h400
`define PMX_OFF_CTRL 12'he04
`define PMX_OFF_OVS 12'he08
`define PMX_OFF_CNTEN 12'he0c
`define PMX_OFF_CFG 12'he00
`define PMX_OFF_STAT 12'he10
`define PMX_OFF_AGENT 12'he14
// ==========================================================
// Control fields
`define PMX_CTRL_E 0
`define PMX_CTRL_FZO 1
`define PMX_CTRL_HDBG 2
`define PMX_CTRL_DP 3
`define PMX_CTRL_CCD 4
// Config fields
`define PMX_CFG_N_LSB 0
`define PMX_CFG_NCG_LSB 8
`define PMX_CFG_CC 12
`define PMX_CFG_CCD 13
`define PMX_CFG_FZO 14
`define PMX_CFG_HDBG 15
// Event type codes
`define PMX_EVT_CHAIN 8'h1e
// Prescale and cycle counter index
`define PMX_PRESCALE 7'd64
`define PMX_CC_IDX 31
`endif

// ===== rtl/pmx_pkg.sv
package pmx_pkg;
  typedef enum logic [1:0] {
    PMX_STOP,
    PMX_RUN,
    PMX_WAIT
  } pmx_state_t;
  // AHB-Lite slave inputs grouped
  typedef struct packed {
    logic sel;
    logic [1:0] trans;
    logic write;
    logic [2:0] size;
    logic [11:0] addr;
    logic ready;
  } pmx_ahb_req_t;
endpackage

// ===== rtl/pmx_counters.sv
// Decided for this implementation: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
`include "pmx_defs.svh"
module pmx_counters #(
  parameter int NUM_CNT = 32,
  parameter int CNT_W = 32,
  parameter int NUM_GRP = 1,
  parameter int NUM_EVT = 8,
  parameter bit HAS_CC = 1'b1,
  parameter bit HAS_PRESCALE = 1'b1,
  parameter bit CC_IN_WAIT = 1'b1,
  parameter bit IGNORE_CHAINED_FLAG = 1'b1,
  parameter int DEBUG_POLICY = 2
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Monitored agent
  input wire logic [NUM_EVT-1:0] event_i,
  input wire logic agent_debug_i,
  input wire logic agent_second_state_i,
  // Status
  output logic [1:0] run_state_o
);
  // ==========================================================
  // Elaboration checks
  // Per-group maximum from the group count and the counter width
  localparam int MAXG = (NUM_GRP <= 4) ? 32 :
    (NUM_GRP <= 8) ? ((CNT_W > 32) ? 16 : 32) : ((CNT_W > 32) ? 8 : 16);
  // Bits needed to pick one event line
  localparam int EW = (NUM_EVT > 1) ? $clog2(NUM_EVT) : 1;
  // counters covered by all NUM_GRP groups of MAXG counters each
  localparam int GRP_SPAN = MAXG * NUM_GRP;
  // Refused settings stop elaboration here, so that no counter
  // misbehaves quietly later on
  // group count within the table
  if (NUM_GRP < 1 || NUM_GRP > 16) begin : g_bad_groups
    $error("pmx: group count out of range");
  end
  // counter count within one register row
  if (NUM_CNT > 32 || NUM_CNT < 2) begin : g_bad_count
    $error("pmx: counter count out of range");
  end
  // every counter inside an implemented group
  if (NUM_CNT > GRP_SPAN) begin : g_bad_span
    $error("pmx: counters beyond the last group");
  end
  if (HAS_CC && NUM_CNT != 32) begin : g_bad_cc
    $error("pmx: cycle counter needs 32 counters");
  end
  // prescaler only on a narrow cycle counter
  if (HAS_PRESCALE && (!HAS_CC || CNT_W > 32)) begin : g_bad_presc
    $error("pmx: prescaler needs narrow cycle counter");
  end
  // wait behaviour needs the cycle counter
  if (CC_IN_WAIT && !HAS_CC) begin : g_bad_wait
    $error("pmx: wait counting needs the cycle counter");
  end
  // Wider counters would need split register words
  if (CNT_W > 32 || CNT_W < 2) begin : g_bad_width
    $error("pmx: unsupported counter width");
  end
  // Event codes must stay below the carry code
  if (NUM_EVT < 1 || NUM_EVT > 30) begin : g_bad_events
    $error("pmx: event count out of range");
  end
  if (DEBUG_POLICY < 0 || DEBUG_POLICY > 2) begin : g_bad_policy
    $error("pmx: unsupported debug policy");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [NUM_CNT-1:0][CNT_W-1:0] cnt;
    logic [NUM_CNT-1:0][7:0] evtype;
    logic [NUM_CNT-1:0] ovs;
    logic [NUM_CNT-1:0] cnten;
    logic [4:0] ctrl;
    logic [5:0] presc;
    logic d_ph;
    logic d_wr;
    logic [11:0] d_addr;
    logic [31:0] rdata;
    pmx_pkg::pmx_state_t st;
    logic [2:0] dbg_s;
    logic [2:0] sec_s;
    logic dbg;
    logic sec;
  } pmx_st_t;
  pmx_st_t r;
  pmx_st_t next_r;

  // Config identity word
  logic [31:0] cfg_word;
  logic [NUM_CNT-1:0] app_ovs;
  logic [NUM_CNT-1:0] inc;
  logic [NUM_CNT-1:0] ovf;
  logic frozen;
  logic cc_tick;
  logic [CNT_W:0] sum;
  logic [31:0] wd;
  logic [4:0] idx;
  logic [NUM_CNT-1:0] is_cc;
  logic [NUM_CNT-1:0] is_chain;
  logic [NUM_CNT-1:0] evt_hit;
  logic dp_wr;
  logic ap_read;
  logic wr_cnt;
  logic wr_type;
  logic wr_ctrl;
  logic wr_ovs;
  logic wr_en;
  logic [4:0] rd_idx;
  logic rd_cnt;
  logic rd_type;
  logic rd_cfg;
  logic rd_ctrl;
  logic rd_ovs;
  logic rd_en;
  logic rd_stat;
  logic rd_agent;
  logic wait_ok;
  logic run_ok;

  // Configuration register image
  always_comb begin
    cfg_word = 32'h0000_0000;
    cfg_word[`PMX_CFG_N_LSB +: 8] = 8'(NUM_CNT - 1);
    cfg_word[`PMX_CFG_NCG_LSB +: 4] = 4'(NUM_GRP - 1);
    cfg_word[`PMX_CFG_CC] = HAS_CC;
    cfg_word[`PMX_CFG_CCD] = HAS_PRESCALE;
    cfg_word[`PMX_CFG_FZO] = 1'b1;
    cfg_word[`PMX_CFG_HDBG] = (DEBUG_POLICY == 2);
  end

  // Applicable overflow flags, enabled or not
  always_comb begin
    app_ovs = r.ovs;
    for (int i = 0; i < NUM_CNT; i++) begin
      if (IGNORE_CHAINED_FLAG && i % 2 == 0 && i + 1 < NUM_CNT) begin
        if (is_chain[i+1])
          app_ovs[i] = 1'b0;
      end
    end
    if (HAS_CC && CC_IN_WAIT)
      app_ovs[`PMX_CC_IDX] = 1'b0;
  end

  // Frozen by debug policy
  always_comb begin
    case (DEBUG_POLICY)
      0: frozen = 1'b0;
      1: frozen = r.dbg;
      default: frozen = r.dbg && r.ctrl[`PMX_CTRL_HDBG];
    endcase
  end

  // ==========================================================
  // Counter classes
  // Decided once per counter so the increment loop stays readable
  always_comb begin
    is_cc = '0;
    is_chain = '0;
    evt_hit = '0;
    for (int i = 0; i < NUM_CNT; i++) begin
      is_cc[i] = HAS_CC && i == `PMX_CC_IDX;
      // odd counter on the pair carry
      is_chain[i] = (i % 2 == 1) && r.evtype[i] == `PMX_EVT_CHAIN && !is_cc[i];
      // Codes at or above the event count select nothing
      evt_hit[i] = (32'(r.evtype[i]) < NUM_EVT) && event_i[r.evtype[i][EW-1:0]];
    end
  end

  // Increment requests; even counters first for carry
  always_comb begin
    inc = '0;
    ovf = '0;
    sum = '0;
    cc_tick = (r.sec == 1'b0 || r.ctrl[`PMX_CTRL_DP]) &&
      (!r.ctrl[`PMX_CTRL_CCD] || !HAS_PRESCALE || r.presc == 6'(`PMX_PRESCALE - 1));
    for (int i = 0; i < NUM_CNT; i++) begin
      if (is_cc[i]) begin
        inc[i] = r.cnten[i] && !frozen && cc_tick &&
          (r.st == pmx_pkg::PMX_RUN || (CC_IN_WAIT && r.st == pmx_pkg::PMX_WAIT));
      end else if (is_chain[i]) begin
        inc[i] = r.cnten[i] && ovf[i-1] && r.st == pmx_pkg::PMX_RUN;
      end else begin
        inc[i] = r.cnten[i] && !frozen && r.st == pmx_pkg::PMX_RUN && evt_hit[i];
      end
      sum = {1'b0, r.cnt[i]} + {{CNT_W{1'b0}}, 1'b1};
      ovf[i] = inc[i] && sum[CNT_W];
    end
  end

  // ==========================================================
  // Bus decode
  // Writes decode the held data-phase address, reads the live address
  // phase; only whole-word transfers are taken
  always_comb begin
    // Data-phase writes
    dp_wr = r.d_ph && r.d_wr;
    wr_cnt = dp_wr && r.d_addr[11:7] == 5'h00 && 32'(r.d_addr[6:2]) < NUM_CNT;
    wr_type = dp_wr && r.d_addr[11:7] == 5'h08 && 32'(r.d_addr[6:2]) < NUM_CNT &&
      !(HAS_CC && r.d_addr[6:2] == 5'(`PMX_CC_IDX));
    wr_ctrl = dp_wr && r.d_addr == `PMX_OFF_CTRL;
    wr_ovs = dp_wr && r.d_addr == `PMX_OFF_OVS;
    wr_en = dp_wr && r.d_addr == `PMX_OFF_CNTEN;
    // Address-phase reads
    ap_read = hready_i && hsel_i && htrans_i[1] && !hwrite_i && hsize_i == 3'h2;
    rd_idx = haddr_i[6:2];
    rd_cnt = ap_read && haddr_i[11:7] == 5'h00 && 32'(rd_idx) < NUM_CNT;
    rd_type = ap_read && haddr_i[11:7] == 5'h08 && 32'(rd_idx) < NUM_CNT;
    rd_cfg = ap_read && haddr_i[11:0] == `PMX_OFF_CFG;
    rd_ctrl = ap_read && haddr_i[11:0] == `PMX_OFF_CTRL;
    rd_ovs = ap_read && haddr_i[11:0] == `PMX_OFF_OVS;
    rd_en = ap_read && haddr_i[11:0] == `PMX_OFF_CNTEN;
    rd_stat = ap_read && haddr_i[11:0] == `PMX_OFF_STAT;
    rd_agent = ap_read && haddr_i[11:0] == `PMX_OFF_AGENT;
  end

  always_comb begin
    wait_ok = r.ctrl[`PMX_CTRL_E] && r.ctrl[`PMX_CTRL_FZO] && (|app_ovs);
    run_ok = r.ctrl[`PMX_CTRL_E] && !wait_ok;
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_r = r;
    wd = hwdata_i;
    idx = 5'(r.d_addr[6:2]);
    // Pin synchronisers: a level counts once stages two and three agree,
    // so a glitch shorter than a clock never reaches the counters
    next_r.dbg_s = {r.dbg_s[1:0], agent_debug_i};
    next_r.sec_s = {r.sec_s[1:0], agent_second_state_i};
    if (r.dbg_s[2] == r.dbg_s[1])
      next_r.dbg = r.dbg_s[2];
    if (r.sec_s[2] == r.sec_s[1])
      next_r.sec = r.sec_s[2];
    // Free-running prescale phase
    next_r.presc = r.presc + 6'h01;
    // Counter updates; counter 31 is the cycle counter
    // A wrap sets its flag on the edge that rolls the count to zero
    for (int i = 0; i < NUM_CNT; i++) begin
      if (inc[i])
        next_r.cnt[i] = r.cnt[i] + {{(CNT_W-1){1'b0}}, 1'b1};
      if (ovf[i])
        next_r.ovs[i] = 1'b1;
    end
    // operating state, one edge behind its inputs
    case (r.st)
      pmx_pkg::PMX_STOP: begin
        // Leaves stop only once enabled
        if (run_ok)
          next_r.st = pmx_pkg::PMX_RUN;
        else if (wait_ok)
          next_r.st = pmx_pkg::PMX_WAIT;
      end
      pmx_pkg::PMX_RUN: begin
        // With freeze enabled, any applicable flag freezes the event counters
        if (!r.ctrl[`PMX_CTRL_E])
          next_r.st = pmx_pkg::PMX_STOP;
        else if (wait_ok)
          next_r.st = pmx_pkg::PMX_WAIT;
      end
      pmx_pkg::PMX_WAIT: begin
        // Software clearing the flags releases the freeze
        if (!r.ctrl[`PMX_CTRL_E])
          next_r.st = pmx_pkg::PMX_STOP;
        else if (run_ok)
          next_r.st = pmx_pkg::PMX_RUN;
      end
      default: begin
        // Unused code falls back to stop
        next_r.st = pmx_pkg::PMX_STOP;
      end
    endcase
    // Address phase capture
    if (hready_i) begin
      next_r.d_ph = hsel_i && htrans_i[1] && hsize_i == 3'h2;
      next_r.d_wr = hwrite_i;
      next_r.d_addr = haddr_i[11:0];
    end
    // Write data phase; the decode flags are mutually exclusive
    if (wr_cnt)
      next_r.cnt[idx] = wd[CNT_W-1:0];
    if (wr_type)
      next_r.evtype[idx] = wd[7:0];
    if (wr_ctrl)
      next_r.ctrl = wd[4:0];
    // Set wins over a clear in the same cycle
    if (wr_ovs)
      next_r.ovs = (r.ovs & ~wd[NUM_CNT-1:0]) | ovf;
    if (wr_en)
      next_r.cnten = wd[NUM_CNT-1:0];
    // Prescale control reads zero when the prescaler is absent
    if (!HAS_PRESCALE)
      next_r.ctrl[`PMX_CTRL_CCD] = 1'b0;
    // Read data registered from address phase; it sees this edge's
    // updates, and unmapped addresses read as zero
    next_r.rdata = 32'h0000_0000;
    if (rd_cnt)
      next_r.rdata = 32'(next_r.cnt[rd_idx]);
    else if (rd_type)
      next_r.rdata = {24'h000000, next_r.evtype[rd_idx]};
    else if (rd_cfg)
      next_r.rdata = cfg_word;
    else if (rd_ctrl)
      next_r.rdata = {27'h0, next_r.ctrl};
    else if (rd_ovs)
      next_r.rdata = 32'(next_r.ovs);
    else if (rd_en)
      next_r.rdata = 32'(next_r.cnten);
    else if (rd_stat)
      next_r.rdata = {30'h0, next_r.st};
    else if (rd_agent)
      next_r.rdata = {30'h0, next_r.sec, next_r.dbg};
  end

  // ==========================================================
  // State register
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Bus outputs
  // Zero wait states and always OKAY: every register answers in one
  // data phase, so the slave never has to stall the master
  assign hrdata_o = r.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  // ==========================================================
  // Status output
  assign run_state_o = r.st;
endmodule // pmx_counters

// ===== dv/pmx_properties.sv
`timescale 1ns/10ps
`include "pmx_defs.svh"
module pmx_properties #(
  parameter int NUM_CNT = 32,
  parameter int NUM_GRP = 1
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Bus and status seen at the block
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [1:0] run_state_o
);
  // ==========================================================
  // Shadow of the taken address phase and of enable/freeze
  logic ap_v, ap_w, rd_cfg;
  logic [11:0] ap_a;
  logic [1:0] ctl_q;
  assign rd_cfg = ap_v && !ap_w && ap_a == `PMX_OFF_CFG;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ap_v <= 1'b0;
      ap_w <= 1'b0;
      ap_a <= 12'h000;
      ctl_q <= 2'h0;
    end else begin
      // Control lands at the end of its data phase, as in the block
      if (ap_v && ap_w && ap_a == `PMX_OFF_CTRL) begin
        ctl_q <= hwdata_i[1:0];
      end
      ap_v <= hsel_i && htrans_i[1] && hready_i;
      ap_w <= hwrite_i;
      ap_a <= haddr_i[11:0];
    end
  end
  // ==========================================================
  // Properties
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  a_stop_when_off: assert property (!ctl_q[0] |=> run_state_o == pmx_pkg::PMX_STOP)
    else $error("not stopped while disabled");
  a_run_no_freeze: assert property (ctl_q == 2'b01 |=> run_state_o == pmx_pkg::PMX_RUN)
    else $error("not running without freeze");
  a_wait_needs_freeze: assert property (run_state_o == pmx_pkg::PMX_WAIT |-> $past(ctl_q) == 2'b11)
    else $error("wait without enable and freeze");
  a_run_needs_on: assert property (run_state_o == pmx_pkg::PMX_RUN |-> $past(ctl_q[0]))
    else $error("running while disabled");
  a_cfg_flags: assert property (rd_cfg |-> hrdata_o[15:12] == 4'hf)
    else $error("config presence flags wrong");
  a_cfg_groups: assert property (rd_cfg |-> hrdata_o[11:8] == 4'(NUM_GRP - 1))
    else $error("config group field wrong");
  a_cfg_total: assert property (rd_cfg |-> hrdata_o[7:0] == 8'(NUM_CNT - 1))
    else $error("config counter total wrong");
  a_bus_zero_wait: assert property (hreadyout_o && !hresp_o)
    else $error("bus wait or error response");
endmodule // pmx_properties

// ===== dv/pmx_agent_model.sv
`timescale 1ns/10ps
module pmx_agent_model (
  // Clock, reset and bench controls
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic ev_on_i,
  input wire logic dbg_i,
  input wire logic sec_i,
  // Towards the monitor
  output logic [7:0] event_o,
  output logic debug_o,
  output logic second_o
);
  // Event 0 pulses every cycle while on; levels move just after an edge
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      event_o <= 8'h00;
      debug_o <= 1'b0;
      second_o <= 1'b0;
    end else begin
      event_o <= {7'h00, ev_on_i};
      debug_o <= dbg_i;
      second_o <= sec_i;
    end
  end
endmodule // pmx_agent_model

// ===== dv/tb_perf_monitor_counter_extensions.sv
`timescale 1ns/10ps
`include "pmx_defs.svh"
module tb_perf_monitor_counter_extensions;
  // ==========================================================
  // Signals
  localparam int NCNT = 32;
  localparam int NGRP = 2;
  logic clock_i = 1'b0, sys_rst_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0;
  logic ev_on = 1'b0, dbg = 1'b0, sec = 1'b0;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, rd, d;
  logic hreadyout_o, hresp_o, agent_debug_i, agent_second_state_i;
  logic [7:0] event_i;
  logic [1:0] run_state_o;
  int failures = 0, comparisons = 0, cyc = 0;
  always #5 clock_i = ~clock_i;
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      results();
    end
  end
  pmx_counters #(.NUM_CNT(NCNT), .NUM_GRP(NGRP)) u_dut (
    .clock_i, .sys_rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
    .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .event_i, .agent_debug_i,
    .agent_second_state_i, .run_state_o
  );
  pmx_agent_model u_agent (
    .clock_i, .sys_rst_i, .ev_on_i(ev_on), .dbg_i(dbg), .sec_i(sec), .event_o(event_i),
    .debug_o(agent_debug_i), .second_o(agent_second_state_i)
  );
  // ==========================================================
  // Bus and compare helpers
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] v);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i <= {20'h0, a};
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= v;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask
  // Two reads whose address phases lie n+2 cycles apart; d holds the rise
  task automatic gap(input logic [11:0] a, input int n);
    repeat (2) @(posedge clock_i);
    bus(1'b0, a, 32'h0);
    d = rd;
    repeat (n) @(posedge clock_i);
    bus(1'b0, a, 32'h0);
    d = rd - d;
  endtask
  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_cfg();
    bus(1'b0, `PMX_OFF_CFG, 32'h0);
    chk("cfg", {16'h0, 4'hf, 4'(NGRP - 1), 8'(NCNT - 1)}, rd);
    bus(1'b0, 12'hffc, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("cfg done");
  endtask
  // Even wraps into a chained odd partner; freeze must not trip
  task automatic t_chain();
    bus(1'b1, `PMX_OFF_TYPE0 + 12'h004, {24'h0, `PMX_EVT_CHAIN});
    bus(1'b1, `PMX_OFF_CNT0, 32'hffff_fff8);
    bus(1'b1, `PMX_OFF_CNT0 + 12'h004, 32'h5);
    bus(1'b1, `PMX_OFF_CNTEN, 32'h3);
    bus(1'b1, `PMX_OFF_CTRL, 32'h3);
    ev_on <= 1'b1;
    repeat (20) @(posedge clock_i);
    bus(1'b0, `PMX_OFF_CNT0 + 12'h004, 32'h0);
    chk("chain", 32'h6, rd);
    bus(1'b0, `PMX_OFF_STAT, 32'h0);
    chk("chain run", 32'h1, rd);
    $display("chain done");
  endtask
  // Counter 2 overflows; cycle counter overflows too but is ignored
  task automatic t_wait();
    bus(1'b1, `PMX_OFF_CNT0 + 12'h008, 32'hffff_fff0);
    bus(1'b1, `PMX_OFF_CCNT, 32'hffff_fff0);
    bus(1'b1, `PMX_OFF_CNTEN, 32'h8000_0007);
    repeat (30) @(posedge clock_i);
    bus(1'b0, `PMX_OFF_STAT, 32'h0);
    chk("wait", 32'h2, rd);
    gap(`PMX_OFF_CNT0 + 12'h008, 8);
    chk("frozen", 32'h0, d);
    gap(`PMX_OFF_CCNT, 8);
    chk("cc in wait", 32'ha, d);
    bus(1'b1, `PMX_OFF_CNTEN, 32'h8000_0003);
    bus(1'b0, `PMX_OFF_STAT, 32'h0);
    chk("disabled flag", 32'h2, rd);
    bus(1'b1, `PMX_OFF_OVS, 32'h4);
    repeat (2) @(posedge clock_i);
    bus(1'b0, `PMX_OFF_STAT, 32'h0);
    chk("resume", 32'h1, rd);
    $display("wait done");
  endtask
  task automatic t_debug();
    dbg <= 1'b1;
    bus(1'b1, `PMX_OFF_CTRL, 32'h5);
    repeat (6) @(posedge clock_i);
    gap(`PMX_OFF_CNT0, 8);
    chk("debug halt", 32'h0, d);
    bus(1'b1, `PMX_OFF_CTRL, 32'h1);
    gap(`PMX_OFF_CNT0, 8);
    chk("debug count", 32'ha, d);
    dbg <= 1'b0;
    $display("debug done");
  endtask
  task automatic t_cycle();
    gap(`PMX_OFF_CCNT, 8);
    chk("cc rate", 32'ha, d);
    sec <= 1'b1;
    repeat (6) @(posedge clock_i);
    gap(`PMX_OFF_CCNT, 8);
    chk("second off", 32'h0, d);
    bus(1'b1, `PMX_OFF_CTRL, 32'h9);
    gap(`PMX_OFF_CCNT, 8);
    chk("second on", 32'ha, d);
    bus(1'b1, `PMX_OFF_CTRL, 32'h19);
    gap(`PMX_OFF_CCNT, 126);
    chk("prescale", 32'h2, d);
    $display("cycle done");
  endtask
  initial begin
    repeat (6) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    t_cfg();
    t_chain();
    t_wait();
    t_debug();
    t_cycle();
    results();
  end
endmodule // tb_perf_monitor_counter_extensions
bind pmx_counters pmx_properties #(.NUM_CNT(NUM_CNT), .NUM_GRP(NUM_GRP)) u_props (
  .clock_i, .sys_rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i,
  .hrdata_o, .hreadyout_o, .hresp_o, .run_state_o
);
